// ---- hw/fuc_ctrl.v ----
// Summary of operation
// - Control register resets to zero, kept otherwise
// - Reserved control bits read zero
// - Control register accessible at all times
// - Transmit-low request needs its enable bit
// - Transmit-low request drops on disable, or on clear while FIFO count is above trigger
// - Receive-full request on full or ready
// - Fault and break requests with receive interrupt enable or fault enable
// - Receive-full request drops on clear/disable
// - Fault/break requests drop on clear/disable
// - Transmit enable gates serial transmission
// - Receive enable gates start of reception
// - Receive disable leaves all flags alone
// - Fault enable works with receive enable off
// - Clock select picks internal or pin clock
// - Sixteen-byte transmit FIFO drops overflow writes
// - Flag clears by zero only after read-one

`include "fuc_map.vh"

`default_nettype none

module fuc_ctrl #(
   parameter DEPTH  = `FUC_FIFO_DEPTH,
   parameter AW     = `FUC_FIFO_AW
) (
   input  wire                   clk,
   input  wire                   rst,
   input  wire [`FUC_ADDR_W-1:0] regAddr,
   input  wire [15:0]            regWdata,
   input  wire                   regWr,
   input  wire                   regRd,
   output reg  [15:0]            regRdata_ff,
   input  wire                   txShiftReady,
   output reg                    txLoad_ff,
   output reg  [7:0]             txData_ff,
   input  wire                   rxStartSeen,
   output wire                   rxStart,
   input  wire                   rxFullSet,
   input  wire                   rxReadySet,
   input  wire                   rxFaultSet,
   input  wire                   lineBreakSet,
   input  wire                   overrunSet,
   input  wire                   baudTick,
   input  wire                   serialClockPin,
   output wire                   serialClkEn,
   output wire                   extClockSelect,
   output wire                   txFifoEmptyIrq,
   output wire                   rxFullIrq,
   output wire                   rxFaultIrq,
   output wire                   lineBreakIrq
);

   //-----------------------------------------
   // Register decode
   //-----------------------------------------
   wire wrCtrl  = regWr && (regAddr == `FUC_IDX_CTRL);
   wire wrStat  = regWr && (regAddr == `FUC_IDX_STAT);
   wire wrTx    = regWr && (regAddr == `FUC_IDX_TXDATA);
   wire wrFctl  = regWr && (regAddr == `FUC_IDX_FIFOCTL);
   wire wrLine  = regWr && (regAddr == `FUC_IDX_LINE);
   wire rdStat  = regRd && (regAddr == `FUC_IDX_STAT);
   wire rdLine  = regRd && (regAddr == `FUC_IDX_LINE);

   //-----------------------------------------
   // Control register
   //-----------------------------------------
   reg  [15:0] ctrl_ff;
   wire        txLowIrqEn = ctrl_ff[`FUC_TIE_BIT];
   wire        rxIrqEn    = ctrl_ff[`FUC_RIE_BIT];
   wire        txEnable   = ctrl_ff[`FUC_TE_BIT];
   wire        rxEnable   = ctrl_ff[`FUC_RE_BIT];
   wire        rxFaultEn  = ctrl_ff[`FUC_RX_FAULT_IRQ_EN_BIT];

   always @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= `FUC_CTRL_RESET;
      end else if (wrCtrl) begin
         // Writable regardless of line activity
         ctrl_ff <= regWdata & `FUC_CTRL_MASK;
      end
   end

   //-----------------------------------------
   // FIFO control: trigger level, FIFO reset
   //-----------------------------------------
   reg  [`FUC_TRIG_W-1:0] trig_ff;
   wire                   txFifoReset;

   assign txFifoReset = wrFctl && regWdata[`FUC_TXRST_BIT];

   always @(posedge clk) begin
      if (rst) begin
         trig_ff <= `FUC_TRIG_RESET;
      end else if (wrFctl) begin
         trig_ff <= regWdata[`FUC_TRIG_LSB +: `FUC_TRIG_W];
      end
   end

   //-----------------------------------------
   // Transmit FIFO
   //-----------------------------------------
   reg  [7:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wrPtr_ff;
   reg  [AW-1:0] rdPtr_ff;
   reg  [AW:0]   count_ff;
   wire        full  = (count_ff == DEPTH[AW:0]);
   wire        empty = (count_ff == {(AW+1){1'b0}});
   wire        push  = wrTx && !full;
   // No new byte leaves without transmit enable
   wire        pop   = txShiftReady && txEnable && !empty;
   reg  [AW:0] nxt_count;

   always @* begin
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         nxt_count = count_ff - {{AW{1'b0}}, 1'b1};
      end
   end

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= regWdata[7:0];
      end
   end

   always @(posedge clk) begin
      if (rst || txFifoReset) begin
         wrPtr_ff <= {AW{1'b0}};
         rdPtr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
         end
         count_ff <= nxt_count;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         txLoad_ff <= 1'b0;
         txData_ff <= 8'h00;
      end else begin
         txLoad_ff <= pop;
         if (pop) begin
            txData_ff <= mem[rdPtr_ff];
         end
      end
   end

   //-----------------------------------------
   // Status flags
   //-----------------------------------------
   localparam [15:0] STAT_RST = `FUC_STAT_RESET;
   reg  tx_fifo_low_flag_ff;
   reg  er_ff;
   reg  brk_ff;
   reg  rdf_ff;
   reg  dr_ff;
   reg  overrun_flag_ff;
   // Read-as-one arms, one per clearable flag
   reg  tdfeArm_ff;
   reg  erArm_ff;
   reg  brkArm_ff;
   reg  rdfArm_ff;
   reg  drArm_ff;
   reg  orerArm_ff;

   wire trigAbove = (nxt_count > {1'b0, trig_ff});
   wire tdfeSet   = pop && !trigAbove;
   // Only a zero write after a one read clears
   wire tdfeClr = wrStat && !regWdata[`FUC_TX_FIFO_LOW_FLAG_BIT] && tdfeArm_ff
                  && trigAbove;
   wire erClr   = wrStat && !regWdata[`FUC_ER_BIT] && erArm_ff;
   wire brkClr  = wrStat && !regWdata[`FUC_BRK_BIT] && brkArm_ff;
   wire rdfClr  = wrStat && !regWdata[`FUC_RDF_BIT] && rdfArm_ff;
   wire drClr   = wrStat && !regWdata[`FUC_DR_BIT] && drArm_ff;
   wire orerClr = wrLine && !regWdata[`FUC_OVERRUN_FLAG_BIT] && orerArm_ff;

   // Receive enable takes no part in flag updates
   always @(posedge clk) begin
      if (rst) begin
         tx_fifo_low_flag_ff <= STAT_RST[`FUC_TX_FIFO_LOW_FLAG_BIT];
         er_ff   <= 1'b0;
         brk_ff  <= 1'b0;
         rdf_ff  <= 1'b0;
         dr_ff   <= 1'b0;
         overrun_flag_ff <= 1'b0;
      end else begin
         // Set wins over clear
         tx_fifo_low_flag_ff <= tdfeSet | (tx_fifo_low_flag_ff & ~tdfeClr);
         er_ff   <= rxFaultSet | (er_ff & ~erClr);
         brk_ff  <= lineBreakSet | (brk_ff & ~brkClr);
         rdf_ff  <= rxFullSet | (rdf_ff & ~rdfClr);
         dr_ff   <= rxReadySet | (dr_ff & ~drClr);
         overrun_flag_ff <= overrunSet | (overrun_flag_ff & ~orerClr);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         tdfeArm_ff <= 1'b0;
         erArm_ff   <= 1'b0;
         brkArm_ff  <= 1'b0;
         rdfArm_ff  <= 1'b0;
         drArm_ff   <= 1'b0;
         orerArm_ff <= 1'b0;
      end else begin
         if (rdStat) begin
            tdfeArm_ff <= tx_fifo_low_flag_ff;
            erArm_ff   <= er_ff;
            brkArm_ff  <= brk_ff;
            rdfArm_ff  <= rdf_ff;
            drArm_ff   <= dr_ff;
         end else if (wrStat) begin
            tdfeArm_ff <= 1'b0;
            erArm_ff   <= 1'b0;
            brkArm_ff  <= 1'b0;
            rdfArm_ff  <= 1'b0;
            drArm_ff   <= 1'b0;
         end
         if (rdLine) begin
            orerArm_ff <= overrun_flag_ff;
         end else if (wrLine) begin
            orerArm_ff <= 1'b0;
         end
      end
   end

   //-----------------------------------------
   // Interrupt requests
   //-----------------------------------------
   wire faultGate = rxIrqEn | rxFaultEn;

   assign txFifoEmptyIrq = txLowIrqEn & tx_fifo_low_flag_ff;
   assign rxFullIrq      = rxIrqEn & (rdf_ff | dr_ff);
   assign rxFaultIrq     = faultGate & er_ff;
   assign lineBreakIrq   = faultGate & (brk_ff | overrun_flag_ff);

   //-----------------------------------------
   // Receive start and serial clock
   //-----------------------------------------
   reg pinLast_ff;

   assign rxStart        = rxEnable & rxStartSeen;
   assign extClockSelect = ctrl_ff[`FUC_CKE_BIT];

   always @(posedge clk) begin
      if (rst) begin
         pinLast_ff <= 1'b0;
      end else begin
         pinLast_ff <= serialClockPin;
      end
   end

   // Pin rising edge or internal tick
   assign serialClkEn = extClockSelect ? (serialClockPin & ~pinLast_ff)
                                       : baudTick;

   //-----------------------------------------
   // Read data
   //-----------------------------------------
   reg [15:0] nxt_rdata;

   always @* begin
      nxt_rdata = 16'h0000;
      case (regAddr)
         `FUC_IDX_CTRL:    nxt_rdata = ctrl_ff;
         `FUC_IDX_STAT: begin
            nxt_rdata[`FUC_ER_BIT]   = er_ff;
            nxt_rdata[`FUC_TX_FIFO_LOW_FLAG_BIT] = tx_fifo_low_flag_ff;
            nxt_rdata[`FUC_BRK_BIT]  = brk_ff;
            nxt_rdata[`FUC_RDF_BIT]  = rdf_ff;
            nxt_rdata[`FUC_DR_BIT]   = dr_ff;
         end
         `FUC_IDX_FIFOCTL: begin
            nxt_rdata[`FUC_TRIG_LSB +: `FUC_TRIG_W] = trig_ff;
            nxt_rdata[`FUC_CNT_LSB +: AW+1]         = count_ff;
         end
         `FUC_IDX_LINE:    nxt_rdata[`FUC_OVERRUN_FLAG_BIT] = overrun_flag_ff;
         default:          nxt_rdata = 16'h0000;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         regRdata_ff <= 16'h0000;
      end else if (regRd) begin
         regRdata_ff <= nxt_rdata;
      end else begin
         regRdata_ff <= 16'h0000;
      end
   end

endmodule

`default_nettype wire

// ---- hw/fuc_map.vh ----
`ifndef FUC_MAP_VH
`define FUC_MAP_VH

// Register indexes on the plain port
`define FUC_ADDR_W      3
`define FUC_IDX_CTRL    3'h0
`define FUC_IDX_STAT    3'h1
`define FUC_IDX_TXDATA  3'h2
`define FUC_IDX_FIFOCTL 3'h3
`define FUC_IDX_LINE    3'h4

// Control register
`define FUC_CTRL_RESET  16'h0000
`define FUC_CTRL_MASK   16'h00fa
`define FUC_TIE_BIT     7
`define FUC_RIE_BIT     6
`define FUC_TE_BIT      5
`define FUC_RE_BIT      4
`define FUC_RX_FAULT_IRQ_EN_BIT    3
`define FUC_CKE_BIT     1

// Status register
`define FUC_ER_BIT      7
`define FUC_TX_FIFO_LOW_FLAG_BIT    5
`define FUC_BRK_BIT     4
`define FUC_RDF_BIT     1
`define FUC_DR_BIT      0
`define FUC_STAT_RESET  16'h0020

// Line status register
`define FUC_OVERRUN_FLAG_BIT    0

// FIFO control register
`define FUC_TRIG_LSB    0
`define FUC_TRIG_W      4
`define FUC_TXRST_BIT   4
`define FUC_CNT_LSB     8
`define FUC_TRIG_RESET  4'h0

// Transmit FIFO
`define FUC_FIFO_DEPTH  16
`define FUC_FIFO_AW     4

`endif

// ---- verification/fuc_ctrl_props.sv ----
`default_nettype none
module fuc_ctrl_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [2:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [15:0] regRdata_ff,
   input wire logic        txShiftReady,
   input wire logic        txLoad_ff,
   input wire logic        baudTick,
   input wire logic        serialClkEn,
   input wire logic        extClockSelect,
   input wire logic        txFifoEmptyIrq,
   input wire logic        rxFullIrq,
   input wire logic        rxFaultIrq,
   input wire logic        lineBreakIrq,
   input wire logic        serialClockPin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Control register and request checks
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire logic ctlWr = regWr && regAddr == 3'h0;
   rsvd_zero_a: assert property ($past(regRd && regAddr == 3'h0) |-> (regRdata_ff & 16'hff05) == 16'h0)
      else $error("reserved bits set");
   rdata_idle_a: assert property (!$past(regRd) |-> regRdata_ff == 16'h0)
      else $error("stale read data");
   clk_sel_a: assert property (ctlWr |=> extClockSelect == $past(regWdata[1]))
      else $error("clock select wrong");
   int_clk_a: assert property (!extClockSelect |-> serialClkEn == baudTick)
      else $error("internal clock enable wrong");
   ext_clk_a: assert property (
      extClockSelect |-> serialClkEn == (serialClockPin && !$past(serialClockPin)))
      else $error("pin clock enable wrong");
   tx_off_a: assert property (ctlWr && !regWdata[7] |=> !txFifoEmptyIrq)
      else $error("tx request survives disable");
   rx_off_a: assert property (ctlWr && !regWdata[6] |=> !rxFullIrq)
      else $error("rx request survives disable");
   fault_off_a: assert property (ctlWr && !regWdata[6] && !regWdata[3] |=> !rxFaultIrq && !lineBreakIrq)
      else $error("fault request survives disable");
   irq_hold_a: assert property (
      $fell(txFifoEmptyIrq) || $fell(rxFullIrq) || $fell(rxFaultIrq) || $fell(lineBreakIrq) |-> $past(regWr))
      else $error("request dropped without write");
   load_gate_a: assert property (txLoad_ff |-> $past(txShiftReady))
      else $error("load without shifter ready");
   cover property ($rose(txLoad_ff));
   cover property ($rose(rxFaultIrq));
   cover property ($rose(lineBreakIrq));
   cover property (extClockSelect && serialClkEn);
endmodule
bind fuc_ctrl fuc_ctrl_props fuc_ctrl_props_i (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata_ff,
   .txShiftReady, .txLoad_ff, .baudTick, .serialClkEn, .extClockSelect, .txFifoEmptyIrq, .rxFullIrq,
   .rxFaultIrq, .lineBreakIrq, .serialClockPin);
`default_nettype wire

// ---- verification/fuc_far_end.sv ----
`default_nettype none
module fuc_far_end #(
   parameter int GAP = 3
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       txLoad,
   input  wire logic [7:0] txData,
   input  wire logic       extSel,
   output var  logic       txShiftReady,
   output var  logic       serialClockPin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Shifter side and pin clock
   // ----
   logic [7:0] got[$];
   int         busy;
   always @(posedge clk) begin
      if (rst || busy == 0) begin
         busy <= 0;
      end else begin
         busy <= busy - 1;
      end
      if (txLoad) begin
         got.push_back(txData);
         busy <= GAP;
      end
      serialClockPin <= !rst && extSel && !serialClockPin;
   end
   assign txShiftReady = busy == 0 && !txLoad;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  regAddr = 3'h0;
   logic [15:0] regWdata = 16'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        rxStartSeen = 1'b0;
   logic [4:0]  setP = 5'h0;
   logic        baudTick = 1'b0;
   logic [15:0] regRdata_ff;
   logic [7:0]  txData_ff;
   wire  [3:0]  irq;
   logic        txShiftReady, txLoad_ff, rxStart, serialClockPin, serialClkEn, extClockSelect;
   int          errCount, nChecks, cycleCnt;
   fuc_ctrl fuc_ctrl_i (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata_ff, .txShiftReady,
      .txLoad_ff, .txData_ff, .rxStartSeen, .rxStart, .rxFullSet(setP[4]), .rxReadySet(setP[3]),
      .rxFaultSet(setP[2]), .lineBreakSet(setP[1]), .overrunSet(setP[0]), .baudTick, .serialClockPin,
      .serialClkEn, .extClockSelect, .txFifoEmptyIrq(irq[3]), .rxFullIrq(irq[2]), .rxFaultIrq(irq[1]),
      .lineBreakIrq(irq[0]));
   fuc_far_end fuc_far_end_i (.clk, .rst, .txLoad(txLoad_ff), .txData(txData_ff), .extSel(extClockSelect),
      .txShiftReady, .serialClockPin);
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycleCnt <= cycleCnt + 1;
      baudTick <= cycleCnt % 16 == 15;
      if (cycleCnt == 3000) begin
         errCount++;
         end_sim;
      end
   end
   // ----
   // Bus and check helpers
   // ----
   task cyc;
      @(posedge clk);
   endtask
   task chk(string n, logic [15:0] s, logic [15:0] e);
      nChecks++;
      if (s !== e) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(logic [2:0] a, logic [15:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      cyc;
      regWr <= 1'b0;
      cyc;
   endtask
   task rd(logic [2:0] a, logic [15:0] e);
      regRd <= 1'b1;
      regAddr <= a;
      cyc;
      regRd <= 1'b0;
      @(negedge clk);
      chk("rdata", regRdata_ff, e);
      cyc;
   endtask
   task ck(logic [15:0] e);
      @(negedge clk);
      chk("irq", {12'h0, irq}, e);
      cyc;
   endtask
   task pulse(logic [4:0] v);
      setP <= v;
      cyc;
      setP <= 5'h0;
      cyc;
   endtask
   // ----
   // Scenarios
   // ----
   task t_regs;
      rd(3'h0, 16'h0000);
      ck(16'h0);
      wr(3'h0, 16'hffff);
      rd(3'h0, 16'h00fa);
      rd(3'h7, 16'h0000);
      wr(3'h0, 16'h0000);
      rd(3'h0, 16'h0000);
      $display("test regs done");
   endtask
   task t_tx;
      wr(3'h3, 16'h0010);
      for (int i = 0; i < 17; i++) begin
         wr(3'h2, 16'(i));
      end
      repeat (8) cyc;
      chk("sent", 16'(fuc_far_end_i.got.size()), 16'h0);
      rd(3'h3, 16'h1000);
      rd(3'h1, 16'h0020);
      wr(3'h1, 16'h0000);
      rd(3'h1, 16'h0000);
      wr(3'h0, 16'h00a0);
      ck(16'h0);
      for (int k = 0; k < 300 && fuc_far_end_i.got.size() < 16; k++) begin
         cyc;
      end
      repeat (8) cyc;
      chk("sent", 16'(fuc_far_end_i.got.size()), 16'h10);
      chk("last", {8'h0, fuc_far_end_i.got[15]}, 16'h000f);
      ck(16'h8);
      wr(3'h0, 16'h0020);
      ck(16'h0);
      $display("test tx done");
   endtask
   task t_rx;
      wr(3'h0, 16'h0040);
      pulse(5'h08);
      ck(16'h4);
      wr(3'h1, 16'h0000);
      ck(16'h4);
      rd(3'h1, 16'h0021);
      wr(3'h1, 16'h0000);
      ck(16'h0);
      wr(3'h0, 16'h0008);
      pulse(5'h04);
      ck(16'h2);
      wr(3'h0, 16'h0018);
      wr(3'h0, 16'h0008);
      rd(3'h1, 16'h00a0);
      wr(3'h0, 16'h0040);
      pulse(5'h01);
      ck(16'h3);
      rd(3'h4, 16'h0001);
      wr(3'h4, 16'h0000);
      ck(16'h2);
      pulse(5'h12);
      ck(16'h7);
      rd(3'h1, 16'h00b2);
      wr(3'h1, 16'h0080);
      ck(16'h2);
      wr(3'h0, 16'h0000);
      ck(16'h0);
      $display("test rx done");
   endtask
   task t_pins;
      logic [15:0] n;
      rxStartSeen <= 1'b1;
      @(negedge clk);
      chk("pins", {14'h0, rxStart, extClockSelect}, 16'h0);
      cyc;
      wr(3'h0, 16'h0012);
      @(negedge clk);
      chk("pins", {14'h0, rxStart, extClockSelect}, 16'h3);
      n = 16'h0;
      for (int j = 0; j < 8; j++) begin
         cyc;
         @(negedge clk);
         n = n + {15'h0, serialClkEn};
      end
      chk("pinEdges", n, 16'h4);
      cyc;
      rxStartSeen <= 1'b0;
      wr(3'h0, 16'h0000);
      $display("test pins done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (2) cyc;
      rst <= 1'b0;
      t_regs;
      t_tx;
      t_rx;
      t_pins;
      end_sim;
   end
endmodule
`default_nettype wire
